// ===== include/cam_access_pkg.sv
// Constants, codes and phase type for the CAM memory-access control-state block.
// Assumes one 200 MHz clock and a host that runs one control state per strobe.
//
// Function
// - Direct select low and write: store data word at address from the bus.
// - Direct writes use the mask chosen by configuration, not a command field.
// - Masked writes change only bits where chosen mask is low; select zero unmasks.
// - Every array write sets validity from the validity input: low valid, high empty.
// - Only direct accesses use direct addressing; otherwise the bus is a command code.
// - Direct reads and writes are refused in software control mode.
// - Array reads drive the addressed word and its validity bit out.
// - Code 000 000 write: masked indirect write at the address pointer.
// - Code 000 000 read: read at the address pointer, selected devices only.
// - Code 100 110: indirect access at the pointer, then pointer increments.
// - Code 100 111: indirect access at the pointer, then pointer decrements.
// - Code 000 001 write: write next free location, only in first free device.
// - Code 000 001 read: read top match, then present next match index.
// - Top-match reads leave the data bus undriven when there was no match.
// - Code 000 010 write: masked write at top match, top device only.
// - Code 000 010 read: read top match without advancing the match.
// - Match index shows accessed, next free, or next match location per access kind.
// - Respond only within each state's scope of devices.

package cam_access_pkg;

  // ****************************************
  // Widths and field positions
  // ****************************************
  localparam int ADDR_W   = 12;
  localparam int PAGE_W   = 4;
  localparam int DATA_W   = 32;
  localparam int MSEL_W   = 3;
  localparam int OP_W     = 6;
  localparam int OP_LSB   = 0;
  localparam int MSEL_LSB = 6;
  localparam int IDX_W    = PAGE_W + ADDR_W;
  localparam int NUM_MASK = 8;

  // ****************************************
  // Command codes and reset values
  // ****************************************
  localparam logic [OP_W-1:0]   OP_IND      = 6'h00;
  localparam logic [OP_W-1:0]   OP_NFA_HPMI = 6'h01;
  localparam logic [OP_W-1:0]   OP_HPM      = 6'h02;
  localparam logic [OP_W-1:0]   OP_IND_INC  = 6'h26;
  localparam logic [OP_W-1:0]   OP_IND_DEC  = 6'h27;
  localparam logic [MSEL_W-1:0] MSEL_NONE   = 3'h0;
  localparam logic [ADDR_W-1:0] AR_RESET    = 12'h000;
  localparam logic [IDX_W-1:0]  IDX_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0] WORD_RESET  = 32'h0000_0000;
  localparam int                SYNC_W      = 3 + ADDR_W + DATA_W + 3;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_HOLD = 2'b10
  } phase_t;

endpackage

// ===== rtl/cam_access_ctrl.sv
// Memory read/write control states of a 32-bit wide CAM array with match logic.
// Assumes host pins are asynchronous to MCLK_I and config ports come from MCLK_I logic.
`timescale 1ns/10ps

module cam_access_ctrl
  import cam_access_pkg::*;
#(
  parameter int DEPTH = 4096
) (
  // Clock and reset
  input  wire logic              MCLK_I,
  input  wire logic              RESET_N_I,
  // Host cycle pins
  input  wire logic              CYCLE_STROBE_I,
  input  wire logic              READ_NOT_WRITE_I,
  input  wire logic              DIRECT_ACCESS_SEL_N_I,
  input  wire logic [ADDR_W-1:0] ADDR_CTRL_BUS_I,
  // Data bus, two-way
  input  wire logic [DATA_W-1:0] IO_WORD_BUS_I,
  output logic      [DATA_W-1:0] IO_WORD_BUS_O,
  output logic                   IO_WORD_BUS_OE_N_O,
  // Validity line, two-way
  input  wire logic              VALIDITY_LINE_I,
  output logic                   VALIDITY_LINE_O,
  output logic                   VALIDITY_LINE_OE_N_O,
  // Cascade pins
  input  wire logic              CASCADE_FULL_IN_N_I,
  input  wire logic              CASCADE_MATCH_IN_N_I,
  output logic                   DEVICE_FULL_N_O,
  output logic                   MATCH_FLAG_N_O,
  output logic      [IDX_W-1:0]  MATCH_INDEX_OUT_O,
  // Configuration from local logic
  input  wire logic              SOFT_MODE_I,
  input  wire logic              DEVICE_SELECT_I,
  input  wire logic [MSEL_W-1:0] DIRECT_MASK_SEL_I,
  input  wire logic [PAGE_W-1:0] PAGE_ADDR_I,
  input  wire logic              MASK_WR_I,
  input  wire logic [MSEL_W-1:0] MASK_WR_SEL_I,
  input  wire logic [DATA_W-1:0] MASK_WR_DATA_I,
  input  wire logic              COMPARE_I,
  input  wire logic [DATA_W-1:0] COMPARE_KEY_I,
  input  wire logic              AR_LOAD_I,
  input  wire logic [ADDR_W-1:0] AR_LOAD_VAL_I,
  output logic      [ADDR_W-1:0] ADDR_POINTER_O
);

  // ****************************************
  // Storage and state
  // ****************************************
  logic [DATA_W-1:0] mem      [DEPTH];
  logic [DATA_W-1:0] mask_reg [NUM_MASK];
  logic [DEPTH-1:0]  empty, matched, next_matched, rest_vec;
  logic [SYNC_W-1:0] sync1, sync2;
  logic              strobe_d, strobe_rise;
  phase_t            phase, next_phase;
  logic [ADDR_W-1:0] ar, next_ar;
  logic [IDX_W-1:0]  idx_out, next_idx;
  logic [DATA_W-1:0] io_data, next_data;
  logic              io_oe_n, next_oe_n, vb_out, next_vb, vb_oe_n, next_vb_oe_n;
  logic              full_n, match_n;

  // Decode and datapath wires
  logic              strobe, rnw, dir_n, vin, full_in_n, match_in_n;
  logic [ADDR_W-1:0] ac;
  logic [DATA_W-1:0] din;
  logic [OP_W-1:0]   op;
  logic              wr_en, rd_en, retire;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [MSEL_W-1:0] wr_msel;
  logic [DATA_W-1:0] old_word, cur_mask, wr_word, rd_word;
  logic              rd_vb;
  logic              nfa_found, top_found, rest_found, nfa_ok, top_ok;
  logic [ADDR_W-1:0] nfa_idx, top_idx, rest_idx;

  // ****************************************
  // Pin synchroniser: only sync2 is read by logic
  // ****************************************
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      sync1    <= '0;
      sync2    <= '0;
      strobe_d <= 1'b0;
    end else begin
      sync1    <= {CYCLE_STROBE_I, READ_NOT_WRITE_I, DIRECT_ACCESS_SEL_N_I, ADDR_CTRL_BUS_I,
                   IO_WORD_BUS_I, VALIDITY_LINE_I, CASCADE_FULL_IN_N_I, CASCADE_MATCH_IN_N_I};
      sync2    <= sync1;
      strobe_d <= sync2[SYNC_W-1];
    end
  end

  // Unpack the synchronised bundle
  assign {strobe, rnw, dir_n, ac, din, vin, full_in_n, match_in_n} = sync2;
  assign strobe_rise = strobe && !strobe_d;
  assign op          = ac[OP_LSB +: OP_W];

  // ****************************************
  // Priority encoders: next free, top match and the match after it
  // ****************************************
  first_set_finder #(.WIDTH(DEPTH), .IDX_W(ADDR_W)) u_nfa (
    .vec_i   (empty),
    .found_o (nfa_found),
    .index_o (nfa_idx)
  );

  first_set_finder #(.WIDTH(DEPTH), .IDX_W(ADDR_W)) u_top (
    .vec_i   (matched),
    .found_o (top_found),
    .index_o (top_idx)
  );

  assign rest_vec = matched & ~(DEPTH'(1) << top_idx);

  first_set_finder #(.WIDTH(DEPTH), .IDX_W(ADDR_W)) u_rest (
    .vec_i   (rest_vec),
    .found_o (rest_found),
    .index_o (rest_idx)
  );

  // Scope terms: first free device and top priority device
  assign nfa_ok = !full_in_n && nfa_found;
  assign top_ok = top_found && match_in_n;

  // ****************************************
  // Array datapath: masked merge and read port
  // ****************************************
  always_comb begin
    old_word = mem[wr_addr];
    cur_mask = mask_reg[wr_msel];
    rd_word  = mem[rd_addr];
    rd_vb    = empty[rd_addr];
    if (wr_msel == MSEL_NONE) begin
      wr_word = din;
    end else begin
      wr_word = (old_word & cur_mask) | (din & ~cur_mask);
    end
  end

  // ****************************************
  // Control-state decode; one state runs per strobe rising edge
  // ****************************************
  always_comb begin
    next_phase   = phase;
    next_ar      = ar;
    next_idx     = idx_out;
    next_data    = io_data;
    next_oe_n    = io_oe_n;
    next_vb      = vb_out;
    next_vb_oe_n = vb_oe_n;
    wr_en        = 1'b0;
    rd_en        = 1'b0;
    retire       = 1'b0;
    wr_addr      = ar;
    rd_addr      = ar;
    wr_msel      = ac[MSEL_LSB +: MSEL_W];
    case (phase)
      PH_IDLE: begin
        if (strobe_rise) begin
          next_phase = PH_HOLD;
          if (!dir_n) begin
            // Refused under software mode; mask comes from configuration
            if (!SOFT_MODE_I && DEVICE_SELECT_I) begin
              wr_addr  = ac;
              rd_addr  = ac;
              wr_msel  = DIRECT_MASK_SEL_I;
              wr_en    = !rnw;
              rd_en    = rnw;
              next_idx = {PAGE_ADDR_I, ac};
            end
          end else begin
            case (op)
              OP_IND, OP_IND_INC, OP_IND_DEC: begin
                if (DEVICE_SELECT_I) begin
                  wr_en    = !rnw;
                  rd_en    = rnw;
                  next_idx = {PAGE_ADDR_I, ar};
                  if (op == OP_IND_INC) begin
                    next_ar = ar + 1'b1;
                  end else if (op == OP_IND_DEC) begin
                    next_ar = ar - 1'b1;
                  end
                end
              end
              OP_NFA_HPMI: begin
                if (!rnw && nfa_ok) begin
                  wr_en    = 1'b1;
                  wr_addr  = nfa_idx;
                  next_idx = {PAGE_ADDR_I, nfa_idx};
                end else if (rnw && top_ok) begin
                  rd_en    = 1'b1;
                  rd_addr  = top_idx;
                  retire   = 1'b1;
                  next_idx = {PAGE_ADDR_I, rest_idx};
                end
              end
              OP_HPM: begin
                // No match means no write and no drive
                if (top_ok) begin
                  wr_en    = !rnw;
                  rd_en    = rnw;
                  wr_addr  = top_idx;
                  rd_addr  = top_idx;
                  next_idx = {PAGE_ADDR_I, top_idx};
                end
              end
              default: begin
              end
            endcase
          end
          if (rd_en) begin
            next_data    = rd_word;
            next_oe_n    = 1'b0;
            next_vb      = rd_vb;
            next_vb_oe_n = 1'b0;
          end
        end
      end
      PH_HOLD: begin
        // Drivers stay on until the host drops the strobe
        if (!strobe) begin
          next_phase   = PH_IDLE;
          next_oe_n    = 1'b1;
          next_vb_oe_n = 1'b1;
        end
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
  end

  // ****************************************
  // Match list: compare loads it, increment retires the top entry
  // ****************************************
  always_comb begin
    next_matched = matched;
    if (COMPARE_I) begin
      for (int i = 0; i < DEPTH; i++) begin
        next_matched[i] = !empty[i] && (mem[i] == COMPARE_KEY_I);
      end
    end else if (retire) begin
      next_matched[top_idx] = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      phase   <= PH_IDLE;
      ar      <= AR_RESET;
      idx_out <= IDX_RESET;
      io_data <= WORD_RESET;
      io_oe_n <= 1'b1;
      vb_out  <= 1'b1;
      vb_oe_n <= 1'b1;
      empty   <= '1;
      matched <= '0;
      full_n  <= 1'b1;
      match_n <= 1'b1;
    end else begin
      phase   <= next_phase;
      ar      <= AR_LOAD_I ? AR_LOAD_VAL_I : next_ar;  // Pointer load wins over stepping
      idx_out <= next_idx;
      io_data <= next_data;
      io_oe_n <= next_oe_n;
      vb_out  <= next_vb;
      vb_oe_n <= next_vb_oe_n;
      matched <= next_matched;
      full_n  <= nfa_found;
      match_n <= !top_found;
      if (wr_en) begin
        empty[wr_addr] <= vin;
      end
    end
  end

  // Array and mask storage carry no reset so they map onto RAM
  always_ff @(posedge MCLK_I) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_word;
    end
    if (MASK_WR_I && MASK_WR_SEL_I != MSEL_NONE) begin
      mask_reg[MASK_WR_SEL_I] <= MASK_WR_DATA_I;
    end
  end

  // Outputs
  assign IO_WORD_BUS_O        = io_data;
  assign IO_WORD_BUS_OE_N_O   = io_oe_n;
  assign VALIDITY_LINE_O      = vb_out;
  assign VALIDITY_LINE_OE_N_O = vb_oe_n;
  assign DEVICE_FULL_N_O      = full_n;
  assign MATCH_FLAG_N_O       = match_n;
  assign MATCH_INDEX_OUT_O    = idx_out;
  assign ADDR_POINTER_O       = ar;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);

  wire go = phase == PH_IDLE && strobe_rise;

  property p_soft_refuse;
    go && !dir_n && SOFT_MODE_I |-> !wr_en ##1 io_oe_n;
  endproperty
  a_soft_refuse: assert property (p_soft_refuse) else $error("direct access in soft mode");

  property p_direct_wr;
    go && !dir_n && !rnw && !SOFT_MODE_I && DEVICE_SELECT_I
      |=> idx_out[ADDR_W-1:0] == $past(ac) && empty[$past(ac)] == $past(vin);
  endproperty
  a_direct_wr: assert property (p_direct_wr) else $error("direct write wrong");

  property p_unmasked;
    wr_en && wr_msel == MSEL_NONE |=> mem[$past(wr_addr)] == $past(din);
  endproperty
  a_unmasked: assert property (p_unmasked) else $error("unmasked write wrong");

  property p_masked_keep;
    wr_en && wr_msel != MSEL_NONE
      |=> ((mem[$past(wr_addr)] ^ $past(old_word)) & $past(cur_mask)) == '0;
  endproperty
  a_masked_keep: assert property (p_masked_keep) else $error("masked bit changed");

  property p_read_drive;
    rd_en |=> !io_oe_n && !vb_oe_n && io_data == $past(rd_word) && vb_out == $past(rd_vb);
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven");

  property p_ar_inc;
    go && dir_n && op == OP_IND_INC && DEVICE_SELECT_I && !AR_LOAD_I
      |=> ar == $past(ar) + 1'b1;
  endproperty
  a_ar_inc: assert property (p_ar_inc) else $error("pointer not incremented");

  property p_ar_dec;
    go && dir_n && op == OP_IND_DEC && DEVICE_SELECT_I && !AR_LOAD_I
      |=> ar == $past(ar) - 1'b1;
  endproperty
  a_ar_dec: assert property (p_ar_dec) else $error("pointer not decremented");

  property p_nomatch_float;
    go && dir_n && rnw && (op == OP_HPM || op == OP_NFA_HPMI) && !top_found
      |=> io_oe_n [*2];
  endproperty
  a_nomatch_float: assert property (p_nomatch_float) else $error("bus driven on mismatch");

  property p_nomatch_nowrite;
    go && dir_n && !rnw && op == OP_HPM && !top_found |-> !wr_en;
  endproperty
  a_nomatch_nowrite: assert property (p_nomatch_nowrite) else $error("write on mismatch");

  property p_inc_ma;
    go && dir_n && rnw && op == OP_NFA_HPMI && top_ok && !COMPARE_I
      |=> !matched[$past(top_idx)] && idx_out[ADDR_W-1:0] == $past(rest_idx);
  endproperty
  a_inc_ma: assert property (p_inc_ma) else $error("match not advanced");

  c_direct_read: cover property (go && !dir_n && rnw && rd_en);
  c_nfa_write:   cover property (go && dir_n && op == OP_NFA_HPMI && wr_en);
  c_hpm_read:    cover property (go && dir_n && op == OP_HPM && rd_en);

endmodule

// ===== rtl/first_set_finder.sv
// Priority pick: lowest set index of a vector wins, as lower addresses rank higher.
// Purely combinational; the caller registers whatever leaves the device.
`timescale 1ns/10ps

module first_set_finder #(
  parameter int WIDTH = 4096,
  parameter int IDX_W = 12
) (
  // Candidate vector
  input  wire logic [WIDTH-1:0] vec_i,
  // Result
  output logic                  found_o,
  output logic [IDX_W-1:0]      index_o
);

  // ****************************************
  // Scan from the top so the lowest set bit is the last to assign
  // ****************************************
  always_comb begin
    found_o = |vec_i;
    index_o = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (vec_i[i]) begin
        index_o = IDX_W'(i);
      end
    end
  end

endmodule

// ===== tb/host_ctrl_model.sv
// Host controller model: runs one control state per strobe on the device pins.
// Assumes the bench calls cycle() one step after a rising clock edge.
`timescale 1ns/10ps

module host_ctrl_model
  import cam_access_pkg::*;
(
  // Clock
  input  wire logic              clk_i,
  // Pins toward the device
  output logic                   strobe_o,
  output logic                   rnw_o,
  output logic                   sel_n_o,
  output logic      [ADDR_W-1:0] ac_o,
  output logic      [DATA_W-1:0] word_o,
  output logic                   vld_o,
  // Device drivers of the shared lines
  input  wire logic [DATA_W-1:0] dev_word_i,
  input  wire logic              dev_oe_n_i,
  input  wire logic              dev_v_i,
  input  wire logic              dev_v_oe_n_i
);
  logic [DATA_W-1:0] drv_d;
  logic              drv_v;

  // Shared lines: the device wins while it drives, else the host value
  assign word_o = dev_oe_n_i ? drv_d : dev_word_i;
  assign vld_o  = dev_v_oe_n_i ? drv_v : dev_v_i;

  // Idle pins at time zero
  initial begin
    strobe_o = 1'b0;
    rnw_o    = 1'b1;
    sel_n_o  = 1'b1;
    ac_o     = 12'h000;
    drv_d    = 32'h0000_0000;
    drv_v    = 1'b1;
  end

  // One control state; pins settle two edges before the strobe is seen
  task automatic cycle(input logic rnw, input logic sel_n, input logic [ADDR_W-1:0] ac,
                       input logic [DATA_W-1:0] d, input logic v,
                       output logic [DATA_W-1:0] rd, output logic rv, output logic oe_n);
    rnw_o   = rnw;
    sel_n_o = sel_n;
    ac_o    = ac;
    // Reads: host lets go, so the lines flip rather than keep stale data
    drv_d   = rnw ? ~drv_d : d;
    drv_v   = rnw ? ~drv_v : v;
    repeat (2) @(posedge clk_i);
    #1 strobe_o = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    rd   = word_o;
    rv   = vld_o;
    oe_n = dev_oe_n_i;
    @(posedge clk_i);
    #1 strobe_o = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
endmodule

// ===== tb/tb_cam_memory_access_states.sv
// Self-checking bench for the CAM memory read/write control states.
// Assumes the host model drives the pins and config ports share MCLK_I.
`timescale 1ns/10ps

module tb_cam_memory_access_states
  import cam_access_pkg::*;
;
  localparam logic [PAGE_W-1:0] PG = 4'h5;
  logic              MCLK_I, RESET_N_I, SOFT_MODE_I, DEVICE_SELECT_I, MASK_WR_I;
  logic              CASCADE_FULL_IN_N_I, CASCADE_MATCH_IN_N_I, COMPARE_I, AR_LOAD_I;
  logic [MSEL_W-1:0] DIRECT_MASK_SEL_I, MASK_WR_SEL_I;
  logic [DATA_W-1:0] MASK_WR_DATA_I, COMPARE_KEY_I, rdat;
  logic [ADDR_W-1:0] AR_LOAD_VAL_I;
  wire  logic        stb, rnw, seln, vin, vout, voe, doe, fulln, mflagn;
  wire  logic [ADDR_W-1:0] ac, ptr;
  wire  logic [DATA_W-1:0] din, dout;
  wire  logic [IDX_W-1:0]  idx;
  logic              rvld, roe;
  int                miscompares, compares;

  cam_access_ctrl dut (
    .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .CYCLE_STROBE_I(stb),
    .READ_NOT_WRITE_I(rnw), .DIRECT_ACCESS_SEL_N_I(seln), .ADDR_CTRL_BUS_I(ac),
    .IO_WORD_BUS_I(din), .IO_WORD_BUS_O(dout), .IO_WORD_BUS_OE_N_O(doe),
    .VALIDITY_LINE_I(vin), .VALIDITY_LINE_O(vout), .VALIDITY_LINE_OE_N_O(voe),
    .CASCADE_FULL_IN_N_I(CASCADE_FULL_IN_N_I), .CASCADE_MATCH_IN_N_I(CASCADE_MATCH_IN_N_I),
    .DEVICE_FULL_N_O(fulln), .MATCH_FLAG_N_O(mflagn), .MATCH_INDEX_OUT_O(idx),
    .SOFT_MODE_I(SOFT_MODE_I), .DEVICE_SELECT_I(DEVICE_SELECT_I),
    .DIRECT_MASK_SEL_I(DIRECT_MASK_SEL_I), .PAGE_ADDR_I(PG), .MASK_WR_I(MASK_WR_I),
    .MASK_WR_SEL_I(MASK_WR_SEL_I), .MASK_WR_DATA_I(MASK_WR_DATA_I), .COMPARE_I(COMPARE_I),
    .COMPARE_KEY_I(COMPARE_KEY_I), .AR_LOAD_I(AR_LOAD_I), .AR_LOAD_VAL_I(AR_LOAD_VAL_I),
    .ADDR_POINTER_O(ptr));

  host_ctrl_model host (
    .clk_i(MCLK_I), .strobe_o(stb), .rnw_o(rnw), .sel_n_o(seln), .ac_o(ac),
    .word_o(din), .vld_o(vin), .dev_word_i(dout), .dev_oe_n_i(doe),
    .dev_v_i(vout), .dev_v_oe_n_i(voe));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Index is {page, address}
  task automatic chk_idx(input logic [ADDR_W-1:0] a);
    check({16'h0000, idx}, {16'h0000, PG, a});
  endtask

  function automatic logic [ADDR_W-1:0] cmd(input logic [2:0] ms, input logic [5:0] op);
    return {3'b000, ms, op};
  endfunction

  task automatic wr(input logic sn, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic v);
    host.cycle(1'b0, sn, a, d, v, rdat, rvld, roe);
  endtask

  task automatic rd(input logic sn, input logic [ADDR_W-1:0] a);
    host.cycle(1'b1, sn, a, 32'h0000_0000, 1'b0, rdat, rvld, roe);
  endtask

  // Single-cycle pulses on the config side
  task automatic pulse(input int which);
    if (which == 0) MASK_WR_I = 1'b1;
    else if (which == 1) COMPARE_I = 1'b1;
    else AR_LOAD_I = 1'b1;
    @(posedge MCLK_I);
    #1;
    MASK_WR_I = 1'b0;
    COMPARE_I = 1'b0;
    AR_LOAD_I = 1'b0;
    repeat (2) @(posedge MCLK_I);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_direct();
    check({31'h0, doe}, 32'h1); check({20'h0, ptr}, 32'h0); check({31'h0, fulln}, 32'h1);
    wr(1'b0, 12'h123, 32'hA5A5_0001, 1'b0); chk_idx(12'h123);
    wr(1'b0, 12'h124, 32'h0000_0007, 1'b1);
    rd(1'b0, 12'h124); check({31'h0, rvld}, 32'h1);
    rd(1'b0, 12'h123); check(rdat, 32'hA5A5_0001);
    check({roe, rvld}, 32'h0); chk_idx(12'h123);
    MASK_WR_SEL_I = 3'h1; MASK_WR_DATA_I = 32'hFFFF_0000; pulse(0);
    DIRECT_MASK_SEL_I = 3'h1;
    wr(1'b0, 12'h123, 32'h1234_5678, 1'b0);
    DIRECT_MASK_SEL_I = MSEL_NONE;
    rd(1'b0, 12'h123); check(rdat, 32'hA5A5_5678);
    SOFT_MODE_I = 1'b1;
    wr(1'b0, 12'h123, 32'h0000_0000, 1'b0);
    rd(1'b0, 12'h123); check({31'h0, roe}, 32'h1);
    SOFT_MODE_I = 1'b0;
    rd(1'b0, 12'h123); check(rdat, 32'hA5A5_5678);
  endtask

  task automatic s_indirect();
    AR_LOAD_VAL_I = 12'h010; pulse(2);
    wr(1'b1, cmd(3'h0, OP_IND_INC), 32'h1111_1111, 1'b0);
    check({20'h0, ptr}, 32'h011); chk_idx(12'h010);
    wr(1'b1, cmd(3'h0, OP_IND_DEC), 32'h2222_2222, 1'b0);
    check({20'h0, ptr}, 32'h010);
    wr(1'b1, cmd(3'h1, OP_IND), 32'h3333_3333, 1'b0);
    rd(1'b1, cmd(3'h0, OP_IND_INC)); check(rdat, 32'h1111_3333);
    check({20'h0, ptr}, 32'h011);
    rd(1'b1, cmd(3'h0, OP_IND_DEC)); check(rdat, 32'h2222_2222);
    check({20'h0, ptr}, 32'h010);
    DEVICE_SELECT_I = 1'b0;
    rd(1'b1, cmd(3'h0, OP_IND)); check({31'h0, roe}, 32'h1);
    DEVICE_SELECT_I = 1'b1;
    rd(1'b1, cmd(3'h0, OP_IND)); check(rdat, 32'h1111_3333);
    check({roe, rvld}, 32'h0);
  endtask

  task automatic s_match();
    CASCADE_FULL_IN_N_I = 1'b1;
    wr(1'b1, cmd(3'h0, OP_NFA_HPMI), 32'h4444_4444, 1'b0);
    rd(1'b0, 12'h000); check({31'h0, rvld}, 32'h1);
    CASCADE_FULL_IN_N_I = 1'b0;
    wr(1'b1, cmd(3'h0, OP_NFA_HPMI), 32'h4444_4444, 1'b0); chk_idx(12'h000);
    wr(1'b1, cmd(3'h0, OP_NFA_HPMI), 32'h4444_4444, 1'b0); chk_idx(12'h001);
    COMPARE_KEY_I = 32'hDEAD_0000; pulse(1);
    check({31'h0, mflagn}, 32'h1);
    rd(1'b1, cmd(3'h0, OP_HPM)); check({31'h0, roe}, 32'h1);
    rd(1'b1, cmd(3'h0, OP_NFA_HPMI)); check({31'h0, roe}, 32'h1);
    wr(1'b1, cmd(3'h0, OP_HPM), 32'h5555_5555, 1'b0);
    rd(1'b0, 12'h000); check(rdat, 32'h4444_4444);
    COMPARE_KEY_I = 32'h4444_4444; pulse(1);
    check({31'h0, mflagn}, 32'h0);
    rd(1'b1, cmd(3'h0, OP_HPM)); check(rdat, 32'h4444_4444); chk_idx(12'h000);
    CASCADE_MATCH_IN_N_I = 1'b0;
    rd(1'b1, cmd(3'h0, OP_HPM)); check({31'h0, roe}, 32'h1);
    CASCADE_MATCH_IN_N_I = 1'b1;
    rd(1'b1, cmd(3'h0, OP_NFA_HPMI)); check(rdat, 32'h4444_4444);
    chk_idx(12'h001);
    wr(1'b1, cmd(3'h0, OP_HPM), 32'h6666_6666, 1'b0); chk_idx(12'h001);
    rd(1'b0, 12'h001); check(rdat, 32'h6666_6666);
    rd(1'b0, 12'h000); check(rdat, 32'h4444_4444);
  endtask

  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Clock, reset, sequence and watchdog
  // ****************************************
  initial begin
    MCLK_I = 1'b0;
    forever #2.5 MCLK_I = ~MCLK_I;
  end

  initial begin
    {miscompares, compares} = '0;
    {RESET_N_I, SOFT_MODE_I, MASK_WR_I, COMPARE_I, AR_LOAD_I, CASCADE_FULL_IN_N_I} = '0;
    {DEVICE_SELECT_I, CASCADE_MATCH_IN_N_I} = 2'b11;
    {DIRECT_MASK_SEL_I, MASK_WR_SEL_I, AR_LOAD_VAL_I} = '0;
    {MASK_WR_DATA_I, COMPARE_KEY_I} = '0;
    repeat (4) @(posedge MCLK_I);
    #1 RESET_N_I = 1'b1;
    @(posedge MCLK_I);
    #1;
    s_direct();
    s_indirect();
    s_match();
    test_done();
  end

  // About 30 states of ten cycles each; a wide margin cuts a hang
  initial begin
    #20000;
    miscompares++;
    test_done();
  end
endmodule
